// *** core/csf_pkg.sv ***
// Package: status flag layout, APB map, ALU operation codes and flag arithmetic
package csf_pkg;

    // APB register map (byte addresses)
    localparam logic [7:0] CSF_STATUS_ADDR = 8'h00;   // Status flag register
    localparam logic [7:0] CSF_ADDR_MASK   = 8'hFC;   // Word-aligned decode

    // Field positions inside the status register
    localparam int CSF_BIT_C   = 0;                   // Carry
    localparam int CSF_BIT_AC  = 1;                   // Half carry
    localparam int CSF_BIT_Z   = 2;                   // Zero
    localparam int CSF_BIT_OV  = 3;                   // Overflow
    localparam int CSF_BIT_PDF = 4;                   // Power-down
    localparam int CSF_BIT_TO  = 5;                   // Watchdog time-out
    localparam int CSF_FLAG_W  = 6;                   // Implemented bits

    // Reset value of the six implemented bits
    localparam logic [5:0] CSF_FLAGS_RST = 6'h00;

    // Operation kinds reported by the ALU
    typedef enum logic [2:0] {
        CSF_OP_NONE,                                  // No flag update
        CSF_OP_ADD,                                   // Addition
        CSF_OP_SUB,                                   // Subtraction
        CSF_OP_LOGIC,                                 // Logic result, zero only
        CSF_OP_RLC,                                   // Rotate left through carry
        CSF_OP_RRC                                    // Rotate right through carry
    } csf_op_t;

    // One ALU request: operands, or result in opA for logic ops
    typedef struct packed {
        csf_op_t    op;                               // Operation kind
        logic [7:0] opA;                              // First operand
        logic [7:0] opB;                              // Second operand
        logic       useCarry;                         // Chain carry in
    } csf_alu_req_t;

    // Nibble adder with carry, used for low and high nibbles
    function automatic logic [4:0] csf_add4(input logic [3:0] x,
                                            input logic [3:0] y,
                                            input logic       ci);
        return {1'b0, x} + {1'b0, y} + {4'h0, ci};
    endfunction : csf_add4

endpackage : csf_pkg

// *** core/csf_flag_calc.sv ***
// Flag calculator: derives new arithmetic flags from one ALU request
`timescale 1ns/1ps
module csf_flag_calc
    import csf_pkg::*;
(
    input  wire csf_alu_req_t req,                    // ALU request
    input  wire logic         carryIn,                // Current carry flag
    output logic [7:0]        result,                 // Operation result
    output logic              newC,                   // Next carry
    output logic              newAc,                  // Next half carry
    output logic              newZ,                   // Next zero
    output logic              newOv,                  // Next overflow
    output logic              updC,                   // Carry is updated
    output logic              updArith                // Z updated; AC and OV too except for logic ops
);

    logic [7:0] opB;                                  // B or its complement
    logic       ci;                                   // Chain carry in
    logic [4:0] lo;                                   // Low nibble sum
    logic [4:0] hi;                                   // High nibble sum
    logic       c7;                                   // Carry into bit 7

    // Adder path shared by add and subtract
    always_comb
    begin
        // Subtract is A + ~B + 1, so carry out means no borrow
        opB = (req.op == CSF_OP_SUB) ? ~req.opB : req.opB;
        if (req.useCarry)
        begin
            ci = carryIn;
        end
        else
        begin
            ci = (req.op == CSF_OP_SUB);
        end
        lo = csf_add4(req.opA[3:0], opB[3:0], ci);
        hi = csf_add4(req.opA[7:4], opB[7:4], lo[4]);
        c7 = req.opA[7] ^ opB[7] ^ hi[3];
    end

    // Flag selection per operation
    always_comb
    begin
        result   = req.opA;
        newC     = carryIn;
        newAc    = 1'b0;
        newOv    = 1'b0;
        updC     = 1'b0;
        updArith = 1'b0;
        case (req.op)
            CSF_OP_ADD, CSF_OP_SUB:
            begin
                result   = {hi[3:0], lo[3:0]};
                // (R4) carry or no borrow
                newC     = hi[4];
                // (R3) nibble carry or no borrow
                newAc    = lo[4];
                // (R8) carry in versus out
                newOv    = c7 ^ hi[4];
                updC     = 1'b1;
                updArith = 1'b1;
            end
            CSF_OP_LOGIC:
            begin
                // Logic ops touch zero only; others hold
                updArith = 1'b1;
            end
            CSF_OP_RLC:
            begin
                // (R5) carry rotated through
                result = {req.opA[6:0], carryIn};
                newC   = req.opA[7];
                updC   = 1'b1;
            end
            CSF_OP_RRC:
            begin
                // (R5) carry rotated through
                result = {carryIn, req.opA[7:1]};
                newC   = req.opA[0];
                updC   = 1'b1;
            end
            default:
            begin
                result = req.opA;
            end
        endcase
        // (R9) zero from result
        newZ = (result == 8'h00);
    end

endmodule : csf_flag_calc

// *** core/csf_status_top.sv ***
// Processor status flag register with APB access and ALU/watchdog updates
`timescale 1ns/1ps
// Operation
// (R1) Power-up or watchdog clear clears power-down
// (R2) Halt sets power-down flag
// (R3) Half carry: nibble carry or no borrow
// (R4) Carry: add carry or no borrow
// (R5) Rotate through carry updates carry
// (R6) Time-out set; cleared by power-up/clear/halt
// (R7) Software writes only change arithmetic flags
// (R8) Overflow: carry into MSB differs out
// (R9) Zero flag follows result equals zero; rotates leave Z unchanged here
// (R10) Top two bits read zero
module csf_status_top
    import csf_pkg::*;
(
    input  wire logic         sys_clk,                // 125 MHz core clock
    input  wire logic         rstn,                   // Async power-up reset, low
    input  wire logic         psel,                   // APB select
    input  wire logic         penable,                // APB enable
    input  wire logic         pwrite,                 // APB write
    input  wire logic [7:0]   paddr,                  // APB byte address
    input  wire logic [31:0]  pwdata,                 // APB write data
    output logic      [31:0]  prdata,                 // APB read data
    output logic              pready,                 // APB ready
    output logic              pslverr,                // APB error, unmapped
    input  wire csf_alu_req_t aluReq,                 // ALU flag request
    input  wire logic         haltExec,               // Halt executed, pulse
    input  wire logic         watchdogClearExec,      // Watchdog clear, pulse
    input  wire logic         watchdogTimeout,        // Watchdog time-out, pulse
    output logic      [7:0]   statusFlags,            // Registered flag view
    output logic      [7:0]   aluResult               // Registered ALU result
);

    logic                  rstSync1_r;                // Reset sync stage 1
    logic                  rstSync2_r;                // Reset sync stage 2
    logic                  rstnInt;                   // Synced reset
    logic [CSF_FLAG_W-1:0] flags_r;                   // Implemented flag bits
    logic [CSF_FLAG_W-1:0] flags_nxt;                 // Next flag bits
    logic                  pready_r;                  // Ready register
    logic                  pready_nxt;                // Next ready
    logic                  pslverr_r;                 // Error register
    logic                  pslverr_nxt;               // Next error
    logic [31:0]           prdata_r;                  // Read data register
    logic [31:0]           prdata_nxt;                // Next read data
    logic [7:0]            result_r;                  // Result register
    logic [7:0]            result_nxt;                // Next result
    logic [7:0]            calcResult;                // Calculator result
    logic                  newC;                      // Calculated carry
    logic                  newAc;                     // Calculated half carry
    logic                  newZ;                      // Calculated zero
    logic                  newOv;                     // Calculated overflow
    logic                  updC;                      // Carry update
    logic                  updArith;                  // Z update; AC/OV too except for logic ops
    logic                  hit;                       // Address decodes
    logic                  wrFire;                    // Write completes

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end
        else
        begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstnInt = rstSync2_r;

    // Flag arithmetic lives in its own module
    csf_flag_calc u_calc (
        .req      (aluReq),
        .carryIn  (flags_r[CSF_BIT_C]),
        .result   (calcResult),
        .newC     (newC),
        .newAc    (newAc),
        .newZ     (newZ),
        .newOv    (newOv),
        .updC     (updC),
        .updArith (updArith)
    );

    // Address decode and write completion
    assign hit    = ((paddr & CSF_ADDR_MASK) == CSF_STATUS_ADDR);
    assign wrFire = psel && penable && pready_r && pwrite && hit;

    // APB slave: one wait cycle in the access phase, then ready
    always_comb
    begin
        pready_nxt  = psel && penable && !pready_r;
        pslverr_nxt = psel && penable && !pready_r && !hit;
        prdata_nxt  = prdata_r;
        if (psel && penable && !pready_r)
        begin
            // (R10) upper bits read zero
            prdata_nxt = hit ? {24'h000000, 2'b00, flags_r} : 32'h00000000;
        end
    end

    // Result holds across idle cycles so software sees the last op
    always_comb
    begin
        result_nxt = result_r;
        if (aluReq.op != CSF_OP_NONE)
        begin
            result_nxt = calcResult;
        end
    end

    // Flag next state; hardware events override a software write
    always_comb
    begin
        flags_nxt = flags_r;
        if (wrFire)
        begin
            // (R7) only arithmetic bits writable
            flags_nxt[CSF_BIT_OV:CSF_BIT_C] = pwdata[CSF_BIT_OV:CSF_BIT_C];
        end
        if (updC)
        begin
            flags_nxt[CSF_BIT_C] = newC;
        end
        if (updArith)
        begin
            // Logic ops leave AC and OV alone
            if (aluReq.op != CSF_OP_LOGIC)
            begin
                flags_nxt[CSF_BIT_AC] = newAc;
                flags_nxt[CSF_BIT_OV] = newOv;
            end
            flags_nxt[CSF_BIT_Z] = newZ;
        end
        // (R1) watchdog clear clears power-down
        if (watchdogClearExec)
        begin
            flags_nxt[CSF_BIT_PDF] = 1'b0;
        end
        // (R2) halt sets power-down
        if (haltExec)
        begin
            flags_nxt[CSF_BIT_PDF] = 1'b1;
        end
        // (R6) clear first, time-out wins
        if (watchdogClearExec || haltExec)
        begin
            flags_nxt[CSF_BIT_TO] = 1'b0;
        end
        if (watchdogTimeout)
        begin
            flags_nxt[CSF_BIT_TO] = 1'b1;
        end
    end

    // Registers; (R1) (R6) power-up clears system flags
    always_ff @(posedge sys_clk or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            flags_r   <= CSF_FLAGS_RST;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
            result_r  <= 8'h00;
        end
        else
        begin
            flags_r   <= flags_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
            result_r  <= result_nxt;
        end
    end

    // Outputs straight from flops
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign prdata      = prdata_r;
    assign statusFlags = {2'b00, flags_r};
    assign aluResult   = result_r;

    // Reference values for checks
    logic [8:0] chkSum;                               // Plain 9-bit sum
    assign chkSum = {1'b0, aluReq.opA} + {1'b0, aluReq.opB};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstnInt);

    AST_PDF_CLEAR: assert property (watchdogClearExec && !haltExec |=> !statusFlags[4]) // (R1)
        else $error("power-down not cleared by watchdog clear");
    // A watchdog clear right after halt may legally drop the flag again
    AST_PDF_SET: assert property ( // (R2)
        haltExec |=> statusFlags[4] ##1 (statusFlags[4] || $past(watchdogClearExec)))
        else $error("power-down not set by halt");
    AST_HALF_SUB: assert property ( // (R3)
        aluReq.op == CSF_OP_SUB && !aluReq.useCarry
        |=> statusFlags[1] == ($past(aluReq.opA[3:0]) >= $past(aluReq.opB[3:0])))
        else $error("half carry wrong after subtract");
    AST_CARRY_ADD: assert property ( // (R4)
        aluReq.op == CSF_OP_ADD && !aluReq.useCarry |=> statusFlags[0] == $past(chkSum[8]))
        else $error("carry wrong after add");
    AST_CARRY_SUB: assert property ( // (R4)
        aluReq.op == CSF_OP_SUB && !aluReq.useCarry
        |=> statusFlags[0] == ($past(aluReq.opA) >= $past(aluReq.opB)))
        else $error("carry wrong after subtract");
    AST_ROTATE: assert property ( // (R5)
        aluReq.op == CSF_OP_RLC
        |=> statusFlags[0] == $past(aluReq.opA[7]) && aluResult[0] == $past(statusFlags[0]))
        else $error("carry wrong after rotate");
    AST_ROTATE_RIGHT: assert property ( // (R5)
        aluReq.op == CSF_OP_RRC
        |=> statusFlags[0] == $past(aluReq.opA[0]) && aluResult[7] == $past(statusFlags[0]))
        else $error("carry wrong after right rotate");
    AST_TO_SET: assert property (watchdogTimeout |=> statusFlags[5]) // (R6)
        else $error("time-out flag not set");
    AST_TO_CLEAR: assert property ( // (R6)
        (watchdogClearExec || haltExec) && !watchdogTimeout |=> !statusFlags[5])
        else $error("time-out flag not cleared");
    AST_WRITE_KEEP: assert property ( // (R7)
        wrFire && !haltExec && !watchdogClearExec && !watchdogTimeout
        |=> $stable(statusFlags[5:4]))
        else $error("software write changed system flags");
    AST_OVERFLOW: assert property ( // (R8)
        aluReq.op == CSF_OP_ADD && !aluReq.useCarry
        |=> statusFlags[3] == ($past(aluReq.opA[7]) == $past(aluReq.opB[7])
                               && $past(chkSum[7]) != $past(aluReq.opA[7])))
        else $error("overflow wrong after add");
    AST_ZERO: assert property ( // (R9)
        aluReq.op == CSF_OP_LOGIC |=> statusFlags[2] == ($past(aluReq.opA) == 8'h00))
        else $error("zero flag wrong after logic op");
    AST_RESERVED: assert property ( // (R10)
        statusFlags[7:6] == 2'b00 && prdata[31:6] == 26'h0000000)
        else $error("reserved bits not zero");

    COV_HALT: cover property (haltExec ##1 statusFlags[4]);
    COV_WRITE: cover property (wrFire);
    COV_TIMEOUT_CLEAR: cover property (watchdogTimeout ##[1:20] watchdogClearExec);
    COV_ERROR: cover property (pslverr);

endmodule : csf_status_top

// *** dv/csf_testbench.sv ***
// Self-checking testbench for the processor status flag register
`timescale 1ns/1ps
`define CSF_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin numErrors++; \
    $display("FAIL t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
    import csf_pkg::*;
    logic         sys_clk;           // Core clock
    logic         rstn;              // Power-up reset, low
    logic         psel;              // APB select
    logic         penable;           // APB enable
    logic         pwrite;            // APB write
    logic [7:0]   paddr;             // APB address
    logic [31:0]  pwdata;            // APB write data
    logic [31:0]  prdata;            // APB read data
    logic         pready;            // APB ready
    logic         pslverr;           // APB error
    csf_alu_req_t aluReq;            // ALU request
    logic         haltExec;          // Halt pulse
    logic         watchdogClearExec; // Watchdog clear pulse
    logic         watchdogTimeout;   // Time-out pulse
    logic [7:0]   statusFlags;       // Flag view
    logic [7:0]   aluResult;         // Last result
    int           numErrors;         // Mismatches
    int           comparisons;       // Compares made
    logic [31:0]  rdData;            // Captured read data
    logic         rdErr;             // Captured error
    logic         carryMode;         // Chain carry in ALU requests
    csf_status_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .aluReq(aluReq), .haltExec(haltExec),
        .watchdogClearExec(watchdogClearExec), .watchdogTimeout(watchdogTimeout),
        .statusFlags(statusFlags), .aluResult(aluResult));
    // Free-running 8 ns clock
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;
    // Verdict and end of run, shared with the watchdog
    task automatic printVerdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, numErrors);
        if (numErrors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : printVerdict
    // One APB transfer; only the watchdog ends a wait on a dead slave
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : apb
    // One ALU update held for a single cycle, then flags and result compared
    task automatic alu(input csf_op_t op, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] expF, input logic [7:0] expR);
        @(posedge sys_clk);
        aluReq <= '{op: op, opA: a, opB: b, useCarry: carryMode};
        @(posedge sys_clk);
        aluReq <= '{op: CSF_OP_NONE, opA: 8'h00, opB: 8'h00, useCarry: 1'b0};
        #1;
        `CSF_CHK(statusFlags, expF)
        `CSF_CHK(aluResult, expR)
    endtask : alu
    // One-cycle system event pulses {halt, clear, timeout}
    task automatic events(input logic [2:0] ev, input logic [7:0] expF);
        @(posedge sys_clk);
        {haltExec, watchdogClearExec, watchdogTimeout} <= ev;
        @(posedge sys_clk);
        {haltExec, watchdogClearExec, watchdogTimeout} <= 3'h0;
        #1;
        `CSF_CHK(statusFlags, expF)
    endtask : events
    // Reset state, software write masking and unmapped access
    task automatic testRegister();
        `CSF_CHK(statusFlags, 8'h00)
        apb(1'b1, CSF_STATUS_ADDR, 32'hFFFF_FFFF);
        `CSF_CHK(statusFlags, 8'h0F)
        apb(1'b0, CSF_STATUS_ADDR, 32'h0000_0000);
        `CSF_CHK(rdData, 32'h0000_000F)
        apb(1'b0, 8'h04, 32'h0000_0000);
        `CSF_CHK(rdErr, 1'b1)
        `CSF_CHK(rdData, 32'h0000_0000)
        $display("test register done");
    endtask : testRegister
    // Addition, subtraction, logic and rotate flag effects
    task automatic testArith();
        alu(CSF_OP_ADD, 8'hFF, 8'h01, 8'h07, 8'h00);
        alu(CSF_OP_ADD, 8'h7F, 8'h01, 8'h0A, 8'h80);
        alu(CSF_OP_SUB, 8'h05, 8'h03, 8'h03, 8'h02);
        alu(CSF_OP_SUB, 8'h03, 8'h05, 8'h00, 8'hFE);
        alu(CSF_OP_SUB, 8'h80, 8'h01, 8'h09, 8'h7F);
        alu(CSF_OP_LOGIC, 8'h00, 8'h00, 8'h0D, 8'h00);
        alu(CSF_OP_LOGIC, 8'h5A, 8'h00, 8'h09, 8'h5A);
        alu(CSF_OP_RLC, 8'h40, 8'h00, 8'h08, 8'h81);
        alu(CSF_OP_RRC, 8'h01, 8'h00, 8'h09, 8'h00);
        $display("test arith done");
    endtask : testArith
    // Power-down and time-out flags under halt, clear, time-out and writes
    task automatic testSystem();
        events(3'b100, 8'h19);
        events(3'b001, 8'h39);
        // Software write must not disturb the system flags
        apb(1'b1, CSF_STATUS_ADDR, 32'h0000_0000);
        `CSF_CHK(statusFlags, 8'h30)
        events(3'b010, 8'h00);
        events(3'b001, 8'h20);
        events(3'b100, 8'h10);
        $display("test system done");
    endtask : testSystem
    // Mid-run reset must clear both system flags
    task automatic testPowerUp();
        events(3'b001, 8'h30);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        // Two sync flops, then one spare edge before requests
        repeat (3) @(posedge sys_clk);
        #1;
        `CSF_CHK(statusFlags, 8'h00)
        $display("test power-up done");
    endtask : testPowerUp
    // Carry-chained add and subtract, then an unmapped write
    task automatic testCarry();
        apb(1'b1, CSF_STATUS_ADDR, 32'h0000_0001);
        `CSF_CHK(statusFlags, 8'h01)
        carryMode = 1'b1;
        alu(CSF_OP_ADD, 8'hFF, 8'h00, 8'h07, 8'h00);
        alu(CSF_OP_SUB, 8'h03, 8'h03, 8'h07, 8'h00);
        alu(CSF_OP_RRC, 8'h00, 8'h00, 8'h06, 8'h80);
        alu(CSF_OP_SUB, 8'h03, 8'h03, 8'h00, 8'hFF);
        carryMode = 1'b0;
        apb(1'b1, 8'h04, 32'h0000_000F);
        `CSF_CHK(rdErr, 1'b1)
        `CSF_CHK(statusFlags, 8'h00)
        $display("test carry done");
    endtask : testCarry
    // Watchdog: generous span against a hung handshake
    initial
    begin
        #200000;
        numErrors++;
        printVerdict();
    end
    // Main sequence
    initial
    begin
        numErrors = 0;
        comparisons = 0;
        carryMode = 1'b0;
        rstn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        aluReq = '{op: CSF_OP_NONE, opA: 8'h00, opB: 8'h00, useCarry: 1'b0};
        {haltExec, watchdogClearExec, watchdogTimeout} = 3'h0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        // Reset release passes two flops before requests
        repeat (3) @(posedge sys_clk);
        #1;
        testRegister();
        testArith();
        testSystem();
        testPowerUp();
        testCarry();
        printVerdict();
    end
endmodule : testbench
